// [pkg/tcb_pkg.sv]
package tcb_pkg;
  // build configurations
  localparam logic [1:0] CFG_CIRCULAR = 2'h0;
  localparam logic [1:0] CFG_FIFO     = 2'h1;
  localparam logic [1:0] CFG_BUS      = 2'h2;
  // capture modes
  localparam logic [1:0] MODE_CIRC    = 2'h0;
  localparam logic [1:0] MODE_SWFIFO  = 2'h1;
  localparam logic [1:0] MODE_HWFIFO  = 2'h2;
  // register indices, word addressed
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_MODE     = 4'h1;
  localparam logic [3:0] REG_STATUS   = 4'h2;
  localparam logic [3:0] REG_RDATA    = 4'h3;
  localparam logic [3:0] REG_RDATA_HI = 4'h4;
  localparam logic [3:0] REG_FILL     = 4'h5;
  localparam logic [3:0] REG_BURST    = 4'h6;
  localparam logic [3:0] REG_IRQ_STAT = 4'h7;
  localparam logic [3:0] REG_IRQ_MASK = 4'h8;
  localparam logic [3:0] REG_DRAIN    = 4'h9;
  // ctrl fields
  localparam int CTRL_EN_BIT       = 0;
  localparam int CTRL_TRIGSTOP_BIT = 1;
  // status / event bits
  localparam int EV_FULL    = 0;
  localparam int EV_STOPPED = 1;
  localparam int EV_TRIG    = 2;
  localparam int EV_BADMODE = 3;
  localparam int EV_WIDTH   = 4;
  // reset values and write buffer depth limits
  localparam logic [1:0] MODE_RESET  = MODE_CIRC;
  localparam logic [3:0] BURST_RESET = 4'h3;
  localparam int WBUF_MAX = 32;
  localparam int WBUF_MIN = 4;
endpackage : tcb_pkg

// [hdl/tcb_store.sv]
module tcb_store #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  input  wire logic                     clock,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  // flip-flop storage; read data registered
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : tcb_store

// [hdl/tcb_top.sv]
// Overview of operation
// - storage configuration is a build parameter, fixed at run time.
// - circular configuration keeps trace in dedicated SRAM as circular buffer or software FIFO.
// - fifo configuration uses SRAM as circular buffer or FIFO per mode.
// - bus configuration sends trace as AXI master writes.
// - circular mode in all builds; overwrites oldest trace when full (bus build never overwrites; it withholds ATB ready on a full write buffer).
// - circular mode allows no readout until capture stops.
// - circular mode can stop capture automatically on trigger input.
// - hardware FIFO mode only in fifo build; passes trace downstream.
// - hardware FIFO never drops; withholds ATB ready while full.
// - software FIFO in all builds; reads over register port in order (bus build sends trace over AXI; register reads of trace answer zero).
// - fifo build can drain stopped circular buffer downstream.
// - bus build write buffer of flip-flops, depth at most 32.
// - bus build has software-programmable burst length.
// - ATB width is 32, 64 or 128, shared by all ATB ports.
// - memory word twice ATB width; AXI width equals ATB width.
//
// Decided for this implementation: the register offsets and the plain strobed port.
module tcb_top
  import tcb_pkg::*;
#(
  parameter logic [1:0] CONFIG    = tcb_pkg::CFG_FIFO,
  parameter int         ATB_W     = 32,
  parameter int         MEM_AW    = 7,
  parameter int         WBUF_DEPTH = 16
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  trigger_in,
  input  wire logic                  atb_valid,
  input  wire logic [ATB_W-1:0]      atb_data,
  output logic                       atb_ready,
  output logic                       out_valid,
  output logic      [ATB_W-1:0]      out_data,
  input  wire logic                  out_ready,
  output logic                       mem_cen_n,
  output logic                       mem_wen_n,
  output logic      [MEM_AW-1:0]     mem_addr,
  output logic      [2*ATB_W-1:0]    mem_wdata,
  input  wire logic [2*ATB_W-1:0]    mem_rdata,
  output logic                       axi_awvalid,
  output logic      [31:0]           axi_awaddr,
  output logic      [3:0]            axi_awlen,
  input  wire logic                  axi_awready,
  output logic                       axi_wvalid,
  output logic      [ATB_W-1:0]      axi_wdata,
  output logic                       axi_wlast,
  input  wire logic                  axi_wready,
  input  wire logic                  axi_bvalid,
  output logic                       axi_bready,
  output logic                       irq
);
  import tcb_pkg::*;

  localparam int MW  = 2 * ATB_W;
  localparam int WAW = $clog2(WBUF_DEPTH);
  localparam int DEPTH_W = MEM_AW + 1;

  initial begin
    if (!(ATB_W == 32 || ATB_W == 64 || ATB_W == 128)) begin
      $error("atb width must be 32, 64 or 128");
    end
    if (WBUF_DEPTH < WBUF_MIN || WBUF_DEPTH > WBUF_MAX ||
        (WBUF_DEPTH & (WBUF_DEPTH - 1)) != 0) begin
      $error("write buffer depth must be a power of two from 4 to 32");
    end
    if (CONFIG > CFG_BUS) begin
      $error("unknown storage configuration");
    end
  end

  function automatic logic mode_ok(input logic [1:0] m);
    mode_ok = (m == MODE_CIRC) || (m == MODE_SWFIFO) ||
              (m == MODE_HWFIFO && CONFIG == CFG_FIFO);
  endfunction : mode_ok

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RUN = 4'h2, ST_STOP = 4'h4, ST_DRAIN = 4'h8
  } tcb_state_t;

  // control registers
  logic                enable, trig_stop, drain_req;
  logic [1:0]          mode;
  logic [3:0]          burst;
  logic [EV_WIDTH-1:0] irq_stat, irq_mask;
  logic                next_enable, next_trig_stop, next_drain_req;
  logic [1:0]          next_mode;
  logic [3:0]          next_burst;
  logic [EV_WIDTH-1:0] next_irq_stat, next_irq_mask, events;
  tcb_state_t          state, next_state;

  wire wr = reg_write;
  always_comb begin
    next_enable    = enable;
    next_trig_stop = trig_stop;
    next_mode      = mode;
    next_burst     = burst;
    next_irq_mask  = irq_mask;
    next_drain_req = 1'b0;
    if (wr && reg_addr == REG_CTRL) begin
      next_enable    = reg_wdata[CTRL_EN_BIT];
      next_trig_stop = reg_wdata[CTRL_TRIGSTOP_BIT];
    end
    if (state == ST_RUN && trig_stop && trigger_in && mode == MODE_CIRC) begin
      next_enable = 1'b0;
    end
    if (wr && reg_addr == REG_MODE && !enable && mode_ok(reg_wdata[1:0])) begin
      next_mode = reg_wdata[1:0];
    end
    if (wr && reg_addr == REG_BURST) begin
      next_burst = reg_wdata[3:0];
    end
    if (wr && reg_addr == REG_IRQ_MASK) begin
      next_irq_mask = reg_wdata[EV_WIDTH-1:0];
    end
    if (wr && reg_addr == REG_DRAIN && CONFIG == CFG_FIFO) begin
      next_drain_req = reg_wdata[0];
    end
    next_irq_stat = irq_stat;
    if (wr && reg_addr == REG_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~reg_wdata[EV_WIDTH-1:0];
    end
    next_irq_stat = next_irq_stat | events;                            // set wins over clear
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      enable    <= 1'b0;
      trig_stop <= 1'b0;
      mode      <= MODE_RESET;
      burst     <= BURST_RESET;
      irq_mask  <= '0;
      irq_stat  <= '0;
      drain_req <= 1'b0;
    end else begin
      enable    <= next_enable;
      trig_stop <= next_trig_stop;
      mode      <= next_mode;
      burst     <= next_burst;
      irq_mask  <= next_irq_mask;
      irq_stat  <= next_irq_stat;
      drain_req <= next_drain_req;
    end
  end

  // storage pointers
  // memory words hold two ATB beats; a half word is buffered until paired
  logic [MEM_AW-1:0]  wptr, rptr, next_wptr, next_rptr;
  logic [DEPTH_W-1:0] fill, next_fill;
  logic [ATB_W-1:0]   half, next_half;
  logic               half_v, next_half_v, wrapped, next_wrapped;
  logic               rd_pend, next_rd_pend, rd_hi, next_rd_hi;
  logic               rd_due, next_rd_due;
  logic [MW-1:0]      rword, next_rword;
  logic               rword_v, next_rword_v;
  logic               next_atb_ready, next_out_valid;
  logic [ATB_W-1:0]   next_out_data;
  logic               next_cen_n, next_wen_n;
  logic [MEM_AW-1:0]  next_maddr;
  logic [MW-1:0]      next_mwdata;
  logic               wbuf_ready;

  wire full      = fill[MEM_AW];
  wire sram_cfg  = (CONFIG != CFG_BUS);
  wire take      = atb_valid && atb_ready;
  wire capturing = (state == ST_RUN);
  // stored trace is visible only outside capture in circular mode
  wire read_ok   = (mode != MODE_CIRC) || (state == ST_STOP);
  // a read before the word is fetched answers zero and pops nothing
  wire rd_sw     = reg_read && reg_addr == REG_RDATA && read_ok && rword_v;
  wire down_pull = (state == ST_DRAIN || (capturing && mode == MODE_HWFIFO));

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (enable) next_state = ST_RUN;
      ST_RUN:   if (!enable) next_state = ST_STOP;
      ST_STOP:  if (enable) next_state = ST_RUN;
                else if (drain_req && mode == MODE_CIRC) next_state = ST_DRAIN;
      ST_DRAIN: if (fill == '0 && !rword_v && !rd_pend && !rd_due) next_state = ST_STOP;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_comb begin
    next_wptr    = wptr;
    next_rptr    = rptr;
    next_fill    = fill;
    next_half    = half;
    next_half_v  = half_v;
    next_wrapped = wrapped;
    next_rd_pend = 1'b0;
    next_rd_due  = rd_pend;
    next_rd_hi   = rd_hi;
    next_rword   = rword;
    next_rword_v = rword_v;
    next_cen_n   = 1'b1;
    next_wen_n   = 1'b1;
    next_maddr   = mem_addr;
    next_mwdata  = mem_wdata;
    next_out_valid = out_valid && !out_ready;
    next_out_data  = out_data;
    if (state == ST_IDLE && enable) begin
      next_wptr = '0; next_rptr = '0; next_fill = '0;
      next_half_v = 1'b0; next_wrapped = 1'b0; next_rword_v = 1'b0; next_rd_hi = 1'b0;
    end
    // memory answers in the cycle after the one that shows the address
    if (rd_due) begin
      next_rword   = mem_rdata;
      next_rword_v = 1'b1;
    end
    if (sram_cfg && take && capturing) begin
      if (!half_v) begin
        next_half = atb_data; next_half_v = 1'b1;
      end else begin
        next_half_v = 1'b0;
        next_cen_n  = 1'b0;
        next_wen_n  = 1'b0;
        next_maddr  = wptr;
        next_mwdata = {atb_data, half};
        next_wptr   = wptr + 1'b1;
        if (full) begin
          next_rptr    = rptr + 1'b1;
          next_wrapped = 1'b1;
        end else begin
          next_fill = fill + 1'b1;
        end
      end
    end else if (sram_cfg && !rd_pend && !rd_due && !rword_v && fill != '0 &&
                 (state == ST_STOP || down_pull || mode == MODE_SWFIFO)) begin
      // one read per free write slot keeps the port single ported
      next_cen_n   = 1'b0;
      next_maddr   = rptr;
      next_rptr    = rptr + 1'b1;
      next_fill    = fill - 1'b1;
      next_rd_pend = 1'b1;
    end
    if (rword_v && down_pull && (!out_valid || out_ready)) begin
      next_out_valid = 1'b1;
      next_out_data  = rd_hi ? rword[MW-1:ATB_W] : rword[ATB_W-1:0];
      next_rd_hi     = !rd_hi;
      next_rword_v   = !rd_hi ? 1'b1 : 1'b0;
    end else if (rword_v && rd_sw) begin
      next_rd_hi   = !rd_hi;
      next_rword_v = !rd_hi;
    end
    // hardware FIFO back-pressure; circular mode always accepts in SRAM builds, bus build waits on wbuf_ready
    next_atb_ready = next_state == ST_RUN &&
                     (sram_cfg ? !(mode == MODE_HWFIFO && next_fill[MEM_AW])
                               : wbuf_ready);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      wptr <= '0; rptr <= '0; fill <= '0; half <= '0; half_v <= 1'b0;
      wrapped <= 1'b0; rd_pend <= 1'b0; rd_hi <= 1'b0; rword <= '0; rword_v <= 1'b0;
      rd_due <= 1'b0;
      atb_ready <= 1'b0; out_valid <= 1'b0; out_data <= '0;
      mem_cen_n <= 1'b1; mem_wen_n <= 1'b1; mem_addr <= '0; mem_wdata <= '0;
    end else begin
      state <= next_state;
      wptr <= next_wptr; rptr <= next_rptr; fill <= next_fill;
      half <= next_half; half_v <= next_half_v; wrapped <= next_wrapped;
      rd_pend <= next_rd_pend; rd_hi <= next_rd_hi;
      rd_due <= next_rd_due;
      rword <= next_rword; rword_v <= next_rword_v;
      atb_ready <= next_atb_ready; out_valid <= next_out_valid; out_data <= next_out_data;
      mem_cen_n <= next_cen_n; mem_wen_n <= next_wen_n;
      mem_addr <= next_maddr; mem_wdata <= next_mwdata;
    end
  end

  // AXI write buffer (bus configuration)
  logic [WAW:0]     wb_wp, wb_rp, next_wb_wp, next_wb_rp;
  logic [ATB_W-1:0] wb_q;
  logic [31:0]      next_awaddr;
  logic [3:0]       beat, next_beat, next_awlen;
  logic             next_awvalid, next_wvalid, next_wlast, next_bready, in_burst, next_in_burst;
  wire  [WAW:0]     wb_cnt = wb_wp - wb_rp;
  wire              wb_push = (CONFIG == CFG_BUS) && take && capturing;
  wire  [4:0]       blen = (burst >= 4'(WBUF_DEPTH > 16 ? 15 : WBUF_DEPTH - 1))
                           ? 5'(WBUF_DEPTH > 16 ? 15 : WBUF_DEPTH - 1) : {1'b0, burst};
  wire              wb_adv = axi_wvalid && axi_wready;

  assign wbuf_ready = (wb_cnt < (WAW + 1)'(WBUF_DEPTH - 1));

  tcb_store #(.WIDTH(ATB_W), .DEPTH(WBUF_DEPTH)) u_wbuf (
    .clock (clock),
    .we    (wb_push),
    .waddr (wb_wp[WAW-1:0]),
    .wdata (atb_data),
    .raddr (next_wb_rp[WAW-1:0]),
    .rdata (wb_q)
  );

  always_comb begin
    next_wb_wp    = wb_wp + (wb_push ? 1'b1 : 1'b0);
    next_wb_rp    = wb_rp;
    next_awvalid  = axi_awvalid && !axi_awready;
    next_awaddr   = axi_awaddr;
    next_awlen    = axi_awlen;
    next_wvalid   = axi_wvalid;
    next_wlast    = axi_wlast;
    next_beat     = beat;
    next_in_burst = in_burst;
    next_bready   = 1'b1;
    if (!in_burst && wb_cnt > (WAW + 1)'(blen)) begin
      next_in_burst = 1'b1;
      next_awvalid  = 1'b1;
      next_awlen    = blen[3:0];
      next_beat     = '0;
      next_wvalid   = 1'b1;
      next_wlast    = (blen == 5'h0);
    end
    if (wb_adv) begin
      next_wb_rp = wb_rp + 1'b1;
      next_beat  = beat + 1'b1;
      if (axi_wlast) begin
        next_wvalid   = 1'b0;
        next_in_burst = 1'b0;
        next_awaddr   = axi_awaddr + 32'((ATB_W / 8) * (32'(axi_awlen) + 1));
      end else begin
        next_wlast = (beat + 1'b1 == axi_awlen);
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wb_wp <= '0; wb_rp <= '0; beat <= '0; in_burst <= 1'b0;
      axi_awvalid <= 1'b0; axi_awaddr <= '0; axi_awlen <= '0;
      axi_wvalid <= 1'b0; axi_wlast <= 1'b0; axi_bready <= 1'b0;
    end else begin
      wb_wp <= next_wb_wp; wb_rp <= next_wb_rp; beat <= next_beat; in_burst <= next_in_burst;
      axi_awvalid <= next_awvalid; axi_awaddr <= next_awaddr; axi_awlen <= next_awlen;
      axi_wvalid <= next_wvalid; axi_wlast <= next_wlast; axi_bready <= next_bready;
    end
  end
  assign axi_wdata = wb_q;

  // events, interrupt, readback
  logic [31:0] next_rdata;
  logic        next_irq;
  always_comb begin
    events = '0;
    events[EV_FULL]    = sram_cfg && full && capturing;
    events[EV_STOPPED] = (state == ST_RUN) && (next_state == ST_STOP);
    events[EV_TRIG]    = trigger_in && capturing;
    events[EV_BADMODE] = wr && reg_addr == REG_MODE && (enable || !mode_ok(reg_wdata[1:0]));
    next_irq   = |(next_irq_stat & next_irq_mask);
    next_rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        REG_CTRL:     next_rdata = {30'h0, trig_stop, enable};
        REG_MODE:     next_rdata = {30'h0, mode};
        REG_STATUS:   next_rdata = {26'h0, CONFIG, wrapped, full, state == ST_STOP,
                                    state == ST_IDLE};
        REG_RDATA:    next_rdata = rd_sw ? 32'(rd_hi ? rword[MW-1:ATB_W] : rword[ATB_W-1:0])
                                         : 32'h0;
        REG_RDATA_HI: next_rdata = 32'(fill);
        REG_FILL:     next_rdata = 32'(fill);
        REG_BURST:    next_rdata = {28'h0, burst};
        REG_IRQ_STAT: next_rdata = 32'(irq_stat);
        REG_IRQ_MASK: next_rdata = 32'(irq_mask);
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= '0;
      irq       <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      irq       <= next_irq;
    end
  end
endmodule : tcb_top

// [test/tcb_top_sva.sv]
module tcb_top_sva
  import tcb_pkg::*;
#(
  parameter logic [1:0] CONFIG = tcb_pkg::CFG_FIFO,
  parameter int         ATB_W  = 32
) (
  input wire logic             clock,
  input wire logic             reset,
  input wire logic [3:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_write,
  input wire logic             reg_read,
  input wire logic [31:0]      reg_rdata,
  input wire logic             trigger_in,
  input wire logic             atb_ready,
  input wire logic             out_valid,
  input wire logic [ATB_W-1:0] out_data,
  input wire logic             out_ready,
  input wire logic             mem_cen_n,
  input wire logic             mem_wen_n,
  input wire logic             axi_awvalid,
  input wire logic             axi_wvalid
);
  import tcb_pkg::*;
  logic       en_h, trs_h, stop_h, next_en, next_trs, next_stop;
  logic [1:0] mode_h, next_mode, run_cnt, next_cnt;
  // shadow of the control state, rebuilt from the register writes and the trigger input
  always_comb begin
    next_en   = en_h;
    next_trs  = trs_h;
    next_stop = stop_h;
    next_mode = mode_h;
    next_cnt  = (run_cnt == 2'h3) ? run_cnt : run_cnt + 2'h1;
    if (reg_write && reg_addr == REG_CTRL) begin
      next_en   = reg_wdata[CTRL_EN_BIT];
      next_trs  = reg_wdata[CTRL_TRIGSTOP_BIT];
      next_stop = 1'b0;
      next_cnt  = 2'h0;
    end
    if (reg_write && reg_addr == REG_MODE && (!en_h || stop_h) &&
        (reg_wdata[1:0] != MODE_HWFIFO || CONFIG == CFG_FIFO)) begin
      next_mode = reg_wdata[1:0];
    end
    if (en_h && trs_h && mode_h == MODE_CIRC && trigger_in) begin
      next_stop = 1'b1;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      en_h    <= 1'b0;
      trs_h   <= 1'b0;
      stop_h  <= 1'b0;
      mode_h  <= MODE_RESET;
      run_cnt <= 2'h0;
    end else begin
      en_h    <= next_en;
      trs_h   <= next_trs;
      stop_h  <= next_stop;
      mode_h  <= next_mode;
      run_cnt <= next_cnt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire running = en_h && mode_h == MODE_CIRC && !stop_h && run_cnt == 2'h3;
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_mode_locked: assert property (reg_read && reg_addr == REG_MODE |=>
    reg_rdata[1:0] == mode_h) else $error("mode changed while enabled");
  a_circ_hidden: assert property (en_h && mode_h == MODE_CIRC && !stop_h && reg_read
    && reg_addr == REG_RDATA |=> reg_rdata == 32'h0) else $error("trace read while running");
  a_circ_overwrite: assert property (running && !trigger_in |-> atb_ready)
    else $error("circular capture stalled the source");
  a_trig_stop: assert property (running && trs_h && trigger_in |-> ##[1:8] !atb_ready)
    else $error("capture did not stop on trigger");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("downstream beat dropped or changed");
  a_mem_write: assert property (!mem_wen_n |-> !mem_cen_n)
    else $error("memory write without chip enable");
  a_no_axi: assert property (CONFIG != CFG_BUS |-> !axi_awvalid && !axi_wvalid)
    else $error("bus write outside bus build");
  c_trig: cover property (running && trs_h && trigger_in);
  c_stall: cover property (en_h && mode_h == MODE_HWFIFO && !atb_ready);
  c_rd: cover property (reg_read && reg_addr == REG_RDATA ##1 reg_rdata != 32'h0);
endmodule : tcb_top_sva

bind tcb_top tcb_top_sva #(.CONFIG(CONFIG), .ATB_W(ATB_W)) u_sva (
  .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .trigger_in(trigger_in), .atb_ready(atb_ready), .out_valid(out_valid),
  .out_data(out_data), .out_ready(out_ready), .mem_cen_n(mem_cen_n),
  .mem_wen_n(mem_wen_n), .axi_awvalid(axi_awvalid), .axi_wvalid(axi_wvalid));

// [test/tcb_atb_src.sv]
module tcb_atb_src #(
  parameter int W = 32
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         stall,
  input  wire logic [7:0]   limit,
  input  wire logic [W-1:0] data_in,
  output logic              atb_valid,
  output logic      [W-1:0] atb_data,
  input  wire logic         atb_ready,
  output logic      [7:0]   sent
);
  timeunit 1ns;
  timeprecision 1ns;
  // beat held until ready; data line garbled while idle so stale values never match
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      atb_valid <= 1'b0;
      atb_data  <= '0;
      sent      <= 8'h0;
    end else if (atb_valid) begin
      if (atb_ready) begin
        atb_valid <= 1'b0;
        atb_data  <= ~atb_data;
        sent      <= sent + 8'h1;
      end
    end else if (!stall && sent != limit) begin
      atb_valid <= 1'b1;
      atb_data  <= data_in;
    end else begin
      atb_data <= ~atb_data;
    end
  end
endmodule : tcb_atb_src

// [test/trace_capture_buffer_tb.sv]
module trace_capture_buffer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tcb_pkg::*;
  localparam int AW = 3;
  logic        clock, reset, reg_write, reg_read, trigger_in, atb_valid, atb_ready;
  logic        out_valid, out_ready, src_stall, irq, mem_cen_n, mem_wen_n, drain_rand;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, atb_data, out_data, rd_val, rnd;
  logic [AW-1:0] mem_addr;
  logic [63:0] mem_wdata, mem_rdata;
  logic [63:0] mem [0:7];
  logic [31:0] beats [0:63];
  logic [31:0] got [0:31];
  logic [7:0]  limit, sent;
  int          n_got, miscompares, checked, cycles, base;

  tcb_top #(.CONFIG(CFG_FIFO), .ATB_W(32), .MEM_AW(AW), .WBUF_DEPTH(16)) u_dut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .trigger_in(trigger_in), .atb_valid(atb_valid), .atb_data(atb_data),
    .atb_ready(atb_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .mem_cen_n(mem_cen_n), .mem_wen_n(mem_wen_n),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .axi_awvalid(), .axi_awaddr(), .axi_awlen(), .axi_awready(rnd[9]), .axi_wvalid(),
    .axi_wdata(), .axi_wlast(), .axi_wready(rnd[10]), .axi_bvalid(rnd[11]), .axi_bready(),
    .irq(irq));
  tcb_atb_src #(.W(32)) u_src (
    .clock(clock), .reset(reset), .stall(src_stall), .limit(limit),
    .data_in(beats[sent[5:0]]), .atb_valid(atb_valid), .atb_data(atb_data),
    .atb_ready(atb_ready), .sent(sent));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] act);
    checked++;
    if (act !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, act);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  task automatic sent_done();
    @(posedge clock);
    for (int i = 0; i < 400 && sent !== limit; i++) @(posedge clock);
    cmp("beats_sent", {24'h0, limit}, {24'h0, sent});
  endtask : sent_done
  task automatic collect(input int k, input int first);
    for (int i = 0; i < 3000 && n_got < k; i++) @(posedge clock);
    drain_rand = 0;
    out_ready <= 1'b0;
    for (int i = 0; i < k; i++) cmp("out_beat", beats[first + i], got[i]);
  endtask : collect

  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  // single ported memory, answer one cycle after the address, garbage otherwise
  always @(posedge clock) begin
    if (!mem_cen_n && !mem_wen_n) mem[mem_addr] <= mem_wdata;
    mem_rdata <= (!mem_cen_n && mem_wen_n) ? mem[mem_addr] : ~mem_rdata;
  end
  always @(posedge clock) begin
    rnd       <= xs(rnd);
    src_stall <= rnd[3];
    if (drain_rand) out_ready <= rnd[7];
    if (out_valid && out_ready) begin
      got[n_got[4:0]] <= out_data;
      n_got <= n_got + 1;
    end
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    reset = 1; reg_write = 0; reg_read = 0; reg_addr = 0; reg_wdata = 0;
    trigger_in = 0; out_ready = 0; drain_rand = 0; limit = 0; mem_rdata = 0;
    rnd = 32'h23; src_stall = 0; n_got = 0; cycles = 0; miscompares = 0; checked = 0;
    for (int i = 0; i < 64; i++) beats[i] = xs(i == 0 ? 32'h23 : beats[i - 1]);
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(REG_MODE);
    cmp("mode_reset", 32'h0, rd_val);
    rd(REG_BURST);
    cmp("burst_reset", {28'h0, BURST_RESET}, rd_val);
    rd(4'hf);
    cmp("unmapped", 32'h0, rd_val);
    // software fifo, with a mode change tried in mid-capture
    wr(REG_MODE, {30'h0, MODE_SWFIFO});
    wr(REG_CTRL, 32'h1);
    base = sent;
    limit <= sent + 8'h4;
    sent_done();
    wr(REG_MODE, {30'h0, MODE_HWFIFO});
    rd(REG_MODE);
    cmp("mode_locked", {30'h0, MODE_SWFIFO}, rd_val);
    for (int i = 0; i < 4; i++) begin
      repeat (2) @(posedge clock);
      rd(REG_RDATA);
      cmp("swfifo_word", beats[base + i], rd_val);
    end
    wr(REG_IRQ_MASK, 32'h1 << EV_BADMODE);
    repeat (2) @(posedge clock);
    cmp("irq_set", 32'h1, {31'h0, irq});
    wr(REG_IRQ_STAT, 32'h1 << EV_BADMODE);
    repeat (2) @(posedge clock);
    cmp("irq_clear", 32'h0, {31'h0, irq});
    wr(REG_CTRL, 32'h0);
    // hardware fifo: sink stalls until the queue pushes back
    wr(REG_MODE, {30'h0, MODE_HWFIFO});
    n_got = 0;
    wr(REG_CTRL, 32'h1);
    base = sent;
    limit <= sent + 8'd24;
    repeat (150) @(posedge clock);
    cmp("hw_backpressure", 32'h0, {31'h0, atb_ready});
    cmp("hw_held", 32'h1, {31'h0, sent != limit});
    drain_rand = 1;
    sent_done();
    collect(24, base);
    wr(REG_CTRL, 32'h0);
    // circular: overwrite, hidden while running, stop on trigger, drain
    wr(REG_MODE, {30'h0, MODE_CIRC});
    wr(REG_IRQ_STAT, 32'hf);
    wr(REG_CTRL, 32'h3);
    base = sent;
    limit <= sent + 8'd20;
    sent_done();
    rd(REG_RDATA);
    cmp("circ_hidden", 32'h0, rd_val);
    trigger_in <= 1'b1;
    repeat (2) @(posedge clock);
    trigger_in <= 1'b0;
    repeat (10) @(posedge clock);
    rd(REG_IRQ_STAT);
    cmp("circ_events", 32'h7, rd_val & 32'h7);
    n_got = 0;
    drain_rand = 1;
    wr(REG_DRAIN, 32'h1);
    collect(16, base + 4);
    rd(REG_STATUS);
    cmp("status_drained", {26'h0, CFG_FIFO, 4'ha}, rd_val);
    wrap_up();
  end
endmodule : trace_capture_buffer_tb
